// ==== design/gpio_pkg.sv ====
// Package: register map, reset values and sense codes of the I/O ports
package gpio_pkg;
    // Printed offsets are not all multiples of four: these are indices
    localparam logic [7:0] IDX_PA_PIN_VALUE = 8'h11;
    localparam logic [7:0] IDX_PA_DIRECTION = 8'h12;
    localparam logic [7:0] IDX_PA_DRIVE_STYLE = 8'h13;
    localparam logic [7:0] IDX_PA_LIFT_ENABLE = 8'h14;
    localparam logic [7:0] IDX_PB_PIN_VALUE = 8'h15;
    localparam logic [7:0] IDX_PB_DRIVE_STYLE = 8'h16;
    localparam logic [7:0] IDX_PB_LIFT_ENABLE = 8'h17;
    localparam logic [7:0] IDX_PC_PIN_VALUE = 8'h18;
    localparam logic [7:0] IDX_PD_PIN_VALUE = 8'h19;
    localparam logic [7:0] IDX_PD_DRIVE_STYLE = 8'h1A;
    localparam logic [7:0] IDX_PD_LIFT_ENABLE = 8'h1B;
    localparam logic [7:0] IDX_PC_IRQ_MASK = 8'h1C;
    localparam logic [7:0] IDX_PA_IRQ_MASK = 8'h1D;
    localparam logic [7:0] IDX_SENSE_CTRL = 8'h1E;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] PA_PIN_MASK = 8'h7F;
    localparam logic [7:0] PA_OUT_MASK = 8'h3F;
    localparam logic [7:0] PA_IRQ_MASK_BITS = 8'h3F;
    localparam logic [7:0] SENSE_BITS = 8'hF0;
    localparam int SENSE_A_LSB = 6;
    localparam int SENSE_C_LSB = 4;
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : gpio_pkg

// ==== design/gpio_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module gpio_sync #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : gpio_sync

// ==== design/gpio_irq_detect.sv ====
// Per-port external interrupt detector with shared sense code
`timescale 1ns/1ps
module gpio_irq_detect (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] level_in,
    input wire logic [7:0] enable,
    input wire logic [1:0] sense,
    input wire logic clear_pending,
    output logic irq_req
);
    logic [7:0] prev_q;
    logic [7:0] hit;
    logic pend_q;
    logic edge_any;
    logic low_any;

    // Per-pin event qualified by its enable
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            case (sense)
                gpio_pkg::SENSE_RISE: hit[i] = level_in[i] & ~prev_q[i];
                gpio_pkg::SENSE_BOTH: hit[i] = level_in[i] ^ prev_q[i];
                default: hit[i] = ~level_in[i] & prev_q[i];
            endcase
        end
    end

    assign edge_any = |(hit & enable);
    assign low_any = (sense == gpio_pkg::SENSE_FALL_LOW)
        && |(~level_in & enable);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Same as the synchroniser's reset output: no edge at release
            prev_q <= 8'h00;
        end else begin
            prev_q <= level_in;
        end
    end

    // Event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
        end else if (edge_any) begin
            pend_q <= 1'b1;
        end else if (clear_pending) begin
            pend_q <= 1'b0;
        end
    end

    assign irq_req = pend_q | low_any;
endmodule : gpio_irq_detect

// ==== design/gpio_ports.sv ====
// Top: I/O ports A to D with AHB-Lite register slave
`timescale 1ns/1ps
module gpio_ports (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pa_pullup,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    output logic [7:0] pb_pullup,
    input wire logic [7:0] pc_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe,
    output logic [7:0] pd_pullup,
    input wire logic [7:0] pa_alt_en,
    input wire logic [7:0] pa_alt_out,
    input wire logic [7:0] pa_alt_push_pull,
    input wire logic [7:0] pb_alt_en,
    input wire logic [7:0] pb_alt_out,
    input wire logic [7:0] pb_alt_push_pull,
    input wire logic [7:0] pd_alt_en,
    input wire logic [7:0] pd_alt_out,
    input wire logic [7:0] pd_alt_push_pull,
    output logic [7:0] pa_periph_in,
    output logic [7:0] pc_periph_in,
    output logic irq_port_a,
    output logic irq_port_c
);
    logic [7:0] pa_data_q;
    logic [7:0] pa_dir_q;
    logic [7:0] pa_drive_q;
    logic [7:0] pa_lift_q;
    logic [7:0] pb_data_q;
    logic [7:0] pb_drive_q;
    logic [7:0] pb_lift_q;
    logic [7:0] pc_data_q;
    logic [7:0] pd_data_q;
    logic [7:0] pd_drive_q;
    logic [7:0] pd_lift_q;
    logic [7:0] pc_irq_en_q;
    logic [7:0] pa_irq_en_q;
    logic [7:0] sense_q;
    logic wr_pend_q;
    logic [gpio_pkg::IDX_W-1:0] wr_idx_q;
    logic [7:0] pa_sync;
    logic [7:0] pc_sync;
    logic [7:0] pa_dir_eff;
    logic [7:0] pa_level;
    logic [7:0] rd_byte;
    logic [gpio_pkg::IDX_W-1:0] addr_idx;
    logic addr_ok;
    logic [7:0] wbyte;
    logic sense_clear;
    logic [7:0] pa_irq_gate;

    gpio_sync #(.W(8)) u_sync_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pa_in),
        .sync_out(pa_sync)
    );

    gpio_sync #(.W(8)) u_sync_c (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pc_in),
        .sync_out(pc_sync)
    );

    // Address phase decode; word index from the byte address
    assign addr_idx = haddr[gpio_pkg::IDX_LSB +: gpio_pkg::IDX_W];
    assign addr_ok = hsel && hready
        && (htrans == gpio_pkg::HTRANS_NONSEQ
        || htrans == gpio_pkg::HTRANS_SEQ);
    assign wbyte = hwdata[7:0];

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_idx_q <= addr_idx;
        end
    end

    // Port A data latch; written whatever the direction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_data_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PA_PIN_VALUE) begin
            pa_data_q <= wbyte;
        end
    end

    // Pin 6 and 7 cannot become outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_dir_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PA_DIRECTION) begin
            pa_dir_q <= wbyte & gpio_pkg::PA_OUT_MASK;
        end
    end

    // Drive style and pull-up enables, one register each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_drive_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PA_DRIVE_STYLE) begin
            pa_drive_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_lift_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PA_LIFT_ENABLE) begin
            pa_lift_q <= wbyte & gpio_pkg::PA_OUT_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_drive_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PB_DRIVE_STYLE) begin
            pb_drive_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_lift_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PB_LIFT_ENABLE) begin
            pb_lift_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_drive_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PD_DRIVE_STYLE) begin
            pd_drive_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_lift_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PD_LIFT_ENABLE) begin
            pd_lift_q <= wbyte;
        end
    end

    // Output-only port latches and the input-only port C latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_data_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PB_PIN_VALUE) begin
            pb_data_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_data_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PC_PIN_VALUE) begin
            pc_data_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_data_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q
            && wr_idx_q == gpio_pkg::IDX_PD_PIN_VALUE) begin
            pd_data_q <= wbyte;
        end
    end

    // Interrupt masks and sense codes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_irq_en_q <= gpio_pkg::RESET_BYTE;
            pa_irq_en_q <= gpio_pkg::RESET_BYTE;
            sense_q <= gpio_pkg::RESET_BYTE;
        end else if (wr_pend_q) begin
            case (wr_idx_q)
                gpio_pkg::IDX_PC_IRQ_MASK: pc_irq_en_q <= wbyte;
                gpio_pkg::IDX_PA_IRQ_MASK:
                    pa_irq_en_q <= wbyte & gpio_pkg::PA_IRQ_MASK_BITS;
                gpio_pkg::IDX_SENSE_CTRL:
                    sense_q <= wbyte & gpio_pkg::SENSE_BITS;
                default: ;
            endcase
        end
    end

    // A write that alters the sense bits drops pending requests
    assign sense_clear = wr_pend_q
        && wr_idx_q == gpio_pkg::IDX_SENSE_CTRL
        && ((wbyte & gpio_pkg::SENSE_BITS) != sense_q);

    // Alternate function forces output on pins 0 to 5, direction bits otherwise
    assign pa_dir_eff = (pa_dir_q | pa_alt_en)
        & gpio_pkg::PA_OUT_MASK;

    // Per-pin drive: push-pull drives both levels, open drain only low
    for (genvar i = 0; i < 8; i++) begin : g_drive
        logic a_val;
        logic a_pp;
        logic b_val;
        logic b_pp;
        logic d_val;
        logic d_pp;
        assign a_val = pa_alt_en[i] ? pa_alt_out[i] : pa_data_q[i];
        assign a_pp = pa_alt_en[i] ? pa_alt_push_pull[i]
            : pa_drive_q[i];
        assign b_val = pb_alt_en[i] ? pb_alt_out[i] : pb_data_q[i];
        assign b_pp = pb_alt_en[i] ? pb_alt_push_pull[i] : pb_drive_q[i];
        assign d_val = pd_alt_en[i] ? pd_alt_out[i] : pd_data_q[i];
        assign d_pp = pd_alt_en[i] ? pd_alt_push_pull[i] : pd_drive_q[i];
        assign pa_out[i] = a_val;
        assign pa_oe[i] = pa_dir_eff[i]
            && (a_pp || !a_val);
        assign pb_out[i] = b_val;
        assign pb_oe[i] = b_pp || !b_val;
        assign pd_out[i] = d_val;
        assign pd_oe[i] = d_pp || !d_val;
    end

    // Pull-ups only on output-capable pins
    assign pa_pullup = pa_lift_q;
    assign pb_pullup = pb_lift_q;
    assign pd_pullup = pd_lift_q;

    // Readback: live level for inputs, latch for outputs
    assign pa_level = (pa_dir_eff & pa_data_q)
        | (~pa_dir_eff & pa_sync & gpio_pkg::PA_PIN_MASK);
    assign pa_periph_in = pa_sync & gpio_pkg::PA_PIN_MASK;
    assign pc_periph_in = pc_sync;

    always_comb begin
        case (addr_idx)
            gpio_pkg::IDX_PA_PIN_VALUE: rd_byte = pa_level;
            gpio_pkg::IDX_PA_DIRECTION: rd_byte = pa_dir_q;
            gpio_pkg::IDX_PA_DRIVE_STYLE: rd_byte = pa_drive_q;
            gpio_pkg::IDX_PA_LIFT_ENABLE: rd_byte = pa_lift_q;
            gpio_pkg::IDX_PB_PIN_VALUE: rd_byte = pb_data_q;
            gpio_pkg::IDX_PB_DRIVE_STYLE: rd_byte = pb_drive_q;
            gpio_pkg::IDX_PB_LIFT_ENABLE: rd_byte = pb_lift_q;
            gpio_pkg::IDX_PC_PIN_VALUE: rd_byte = pc_sync;
            gpio_pkg::IDX_PD_PIN_VALUE: rd_byte = pd_data_q;
            gpio_pkg::IDX_PD_DRIVE_STYLE: rd_byte = pd_drive_q;
            gpio_pkg::IDX_PD_LIFT_ENABLE: rd_byte = pd_lift_q;
            gpio_pkg::IDX_PC_IRQ_MASK: rd_byte = pc_irq_en_q;
            gpio_pkg::IDX_PA_IRQ_MASK: rd_byte = pa_irq_en_q;
            gpio_pkg::IDX_SENSE_CTRL: rd_byte = sense_q;
            default: rd_byte = gpio_pkg::RESET_BYTE;
        endcase
    end

    // Captured at the address edge, stands through the data phase.
    // A read overlapping the data phase of a write to the same
    // register returns the value from before that write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= {24'h00_0000, rd_byte};
        end else begin
            hrdata <= hrdata;
        end
    end

    // Output pins are removed from interrupt sources
    assign pa_irq_gate = pa_irq_en_q & ~pa_dir_eff;

    gpio_irq_detect u_irq_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(pa_sync),
        .enable(pa_irq_gate),
        .sense(sense_q[gpio_pkg::SENSE_A_LSB +: 2]),
        .clear_pending(sense_clear),
        .irq_req(irq_port_a)
    );

    gpio_irq_detect u_irq_c (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(pc_sync),
        .enable(pc_irq_en_q),
        .sense(sense_q[gpio_pkg::SENSE_C_LSB +: 2]),
        .clear_pending(sense_clear),
        .irq_req(irq_port_c)
    );

    // Bus bits and the port C latch that nothing reads
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:10], haddr[1:0],
        hwdata[31:8], pc_data_q};
endmodule : gpio_ports

// ==== verification/gpio_ports_properties.sv ====
// Checker: port-level properties of the I/O port block
`timescale 1ns/1ps
module gpio_ports_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pa_alt_en,
    input wire logic [7:0] pa_alt_out,
    input wire logic [7:0] pa_alt_push_pull,
    input wire logic [7:0] pb_alt_en,
    input wire logic [7:0] pb_alt_out,
    input wire logic [7:0] pb_alt_push_pull,
    input wire logic [7:0] pa_periph_in,
    input wire logic [7:0] pc_periph_in
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] age_q;
    // Cycles since reset, so history from reset is not compared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    sequence s_pb_write;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h54;
    endsequence
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    a_bd_drive_kind: assert property (
        &(pb_oe | pb_out) && &(pd_oe | pd_out))
        else $error("released pin not at high level");
    a_alt_value: assert property (
        ((pb_out ^ pb_alt_out) & pb_alt_en) == 8'h00 &&
        ((pa_out ^ pa_alt_out) & pa_alt_en & 8'h3F) == 8'h00)
        else $error("alternate value not on pin");
    a_alt_push: assert property (
        (pb_alt_en & pb_alt_push_pull & ~pb_oe) == 8'h00 &&
        (pa_alt_en & pa_alt_push_pull & ~pa_oe & 8'h3F) == 8'h00)
        else $error("alternate push-pull pin not driven");
    a_pa_top_input: assert property (pa_oe[7:6] == 2'h0)
        else $error("port A pin 6 or 7 driven");
    a_sync_pa: assert property (
        age_q == 2'h3 |-> pa_periph_in == $past(pa_in, 2))
        else $error("port A level not two cycles late");
    a_sync_pc: assert property (
        age_q == 2'h3 |-> pc_periph_in == $past(pc_in, 2))
        else $error("port C level not two cycles late");
    a_pb_latch_load: assert property (
        s_pb_write ##2 1'b1 |=>
        ((pb_out ^ $past(hwdata[7:0], 2)) & ~pb_alt_en) == 8'h00)
        else $error("port B latch not loaded");
endmodule : gpio_ports_properties

bind gpio_ports gpio_ports_properties chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pa_in, .pa_out,
    .pa_oe, .pb_out, .pb_oe, .pd_out, .pd_oe, .pc_in, .pa_alt_en,
    .pa_alt_out, .pa_alt_push_pull, .pb_alt_en, .pb_alt_out,
    .pb_alt_push_pull, .pa_periph_in, .pc_periph_in);

// ==== verification/gpio_pin_world.sv ====
// Pin model: outside drivers facing the port pins
`timescale 1ns/1ps
module gpio_pin_world (
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pa_ext,
    input wire logic [7:0] pc_ext,
    input wire logic [7:0] pc_ext_en,
    output logic [7:0] pa_in,
    output logic [7:0] pc_in
);
    // Driven port A pins show the port level
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    // Released port C pins sit on their pull-ups
    assign pc_in = (pc_ext_en & pc_ext) | ~pc_ext_en;
endmodule : gpio_pin_world

// ==== verification/bidirectional_io_port_tb.sv ====
// Self-checking bench of the I/O port block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module bidirectional_io_port_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, c;
    logic [2:0] hsize;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pullup, pb_out, pb_oe, pb_pullup;
    logic [7:0] pc_in, pd_out, pd_oe, pd_pullup, pa_periph_in, pc_periph_in;
    logic [7:0] pa_alt_en, pa_alt_out, pa_alt_push_pull;
    logic [7:0] pb_alt_en, pb_alt_out, pb_alt_push_pull;
    logic [7:0] pd_alt_en, pd_alt_out, pd_alt_push_pull;
    logic [7:0] pa_ext, pc_ext, pc_ext_en, i;
    logic [7:0] m [8'h11:8'h1E];
    logic irq_port_a, irq_port_c;
    int seed, err_total, cmp_count, k;
    assign hready = hreadyout;
    gpio_ports uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pa_in, .pa_out,
        .pa_oe, .pa_pullup, .pb_out, .pb_oe, .pb_pullup, .pc_in, .pd_out,
        .pd_oe, .pd_pullup, .pa_alt_en, .pa_alt_out, .pa_alt_push_pull,
        .pb_alt_en, .pb_alt_out, .pb_alt_push_pull, .pd_alt_en, .pd_alt_out,
        .pd_alt_push_pull, .pa_periph_in, .pc_periph_in, .irq_port_a,
        .irq_port_c);
    gpio_pin_world pins (.pa_out, .pa_oe, .pa_ext, .pc_ext, .pc_ext_en,
        .pa_in, .pc_in);
    function automatic logic [7:0] r8();
        return 8'($random(seed));
    endfunction : r8
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == 8'h11) begin
            return (m[8'h12] & m[a]) | (~m[8'h12] & pa_ext);
        end
        if (a == 8'h18) begin
            return (pc_ext_en & pc_ext) | ~pc_ext_en;
        end
        return m[a];
    endfunction : exp_rd
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [31:0] q);
        haddr <= {22'h0, a, 2'h0};
        hwrite <= w;
        htrans <= gpio_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
        if (a inside {[8'h11:8'h1E]}) begin
            m[a] = d;
            if (a inside {8'h12, 8'h14, 8'h1D}) m[a] = d & 8'h3F;
            if (a == 8'h1E) m[a] = d & 8'hF0;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        `CHK(q, {24'h0, e})
    endtask : rd
    task automatic chk_pins;
        logic [7:0] ob, pp, oa, da, od;
        ob = (pb_alt_en & pb_alt_out) | (~pb_alt_en & m[8'h15]);
        pp = (pb_alt_en & pb_alt_push_pull) | (~pb_alt_en & m[8'h16]);
        `CHK(pb_out, ob)
        `CHK(pb_oe, pp | ~ob)
        `CHK(pb_pullup, m[8'h17])
        od = (pd_alt_en & pd_alt_out) | (~pd_alt_en & m[8'h19]);
        pp = (pd_alt_en & pd_alt_push_pull) | (~pd_alt_en & m[8'h1A]);
        `CHK(pd_out, od)
        `CHK(pd_oe, pp | ~od)
        `CHK(pd_pullup, m[8'h1B])
        oa = (pa_alt_en & pa_alt_out) | (~pa_alt_en & m[8'h11]);
        da = (m[8'h12] | pa_alt_en) & 8'h3F;
        pp = (pa_alt_en & pa_alt_push_pull) | (~pa_alt_en & m[8'h13]);
        `CHK(pa_oe, da & (pp | ~oa))
        `CHK(pa_out & da, oa & da)
        `CHK(pa_pullup, m[8'h14])
    endtask : chk_pins
    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        report_and_stop;
    end
    initial begin
        seed = 27;
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        {pa_alt_en, pa_alt_out, pa_alt_push_pull} = '0;
        {pb_alt_en, pb_alt_out, pb_alt_push_pull} = '0;
        {pd_alt_en, pd_alt_out, pd_alt_push_pull} = '0;
        {pa_ext, pc_ext, pc_ext_en} = '0;
        foreach (m[j]) m[j] = 8'h00;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_pins;
        for (i = 8'h11; i != 8'h1F; i++) rd(i, exp_rd(i));
        wr(8'h1F, 8'hFF);
        rd(8'h1F, 8'h00);
        repeat (16) begin
            for (i = 8'h11; i != 8'h1C; i++) begin
                if (i != 8'h12) wr(i, r8());
            end
            wr(8'h12, r8() & 8'h3F);
            pa_ext <= r8() & 8'h7F;
            pc_ext <= r8();
            pc_ext_en <= r8();
            {pb_alt_en, pb_alt_out, pb_alt_push_pull} <= {r8(), r8(), r8()};
            {pd_alt_en, pd_alt_out, pd_alt_push_pull} <= {r8(), r8(), r8()};
            pa_alt_en <= r8() & m[8'h12];
            pa_alt_out <= r8();
            pa_alt_push_pull <= r8();
            repeat (4) @(posedge hclk);
            chk_pins;
            for (i = 8'h11; i != 8'h1C; i++) rd(i, exp_rd(i));
        end
        {pa_alt_en, pb_alt_en, pd_alt_en, pa_ext, pc_ext, pc_ext_en} <= '0;
        wr(8'h1C, 8'h81);
        for (k = 1; k < 5; k++) begin
            c = 2'(k);
            wr(8'h1E, {c, c, 4'h0});
            repeat (4) @(posedge hclk);
            `CHK(irq_port_c, 1'b0)
            pc_ext_en <= k[0] ? 8'h80 : 8'h01;
            repeat (5) @(posedge hclk);
            `CHK(irq_port_c, c != 2'h1)
            pc_ext_en <= 8'h00;
            repeat (5) @(posedge hclk);
            `CHK(irq_port_c, 1'b1)
        end
        wr(8'h1E, 8'hC0);
        wr(8'h13, 8'h01);
        wr(8'h12, 8'h01);
        wr(8'h1D, 8'h01);
        wr(8'h11, 8'h01);
        wr(8'h11, 8'h00);
        repeat (5) @(posedge hclk);
        `CHK(irq_port_a, 1'b0)
        wr(8'h12, 8'h00);
        pa_ext <= 8'h01;
        repeat (5) @(posedge hclk);
        `CHK(irq_port_a, 1'b1)
        pa_alt_en <= 8'h02;
        pa_alt_out <= 8'h02;
        pa_alt_push_pull <= 8'h02;
        repeat (4) @(posedge hclk);
        chk_pins;
        `CHK(pa_periph_in, 8'h03)
        `CHK(irq_port_a, 1'b1)
        report_and_stop;
    end
endmodule : bidirectional_io_port_tb
